// File: common/ioopt_pkg.sv
// shared constants and carrier types for the io and low-power option registers
package ioopt_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int IRQ_WIDE_US = 25;
    localparam int IRQ_NARROW_US = 100;
    localparam logic [11:0] IRQ_WIDE_CYC = 12'(IRQ_WIDE_US * CLK_MHZ);
    localparam logic [11:0] IRQ_NARROW_CYC = 12'(IRQ_NARROW_US * CLK_MHZ);

    // ----------------------------------------------------------------
    // serial frame layout
    // ----------------------------------------------------------------
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] BIT_CNT_MAX = 5'h1f;
    localparam int CMD_ACC_HI = 15;
    localparam int CMD_ACC_LO = 14;
    localparam int CMD_ADDR_HI = 13;
    localparam int CMD_ADDR_LO = 9;
    localparam int CMD_PARITY = 8;
    localparam int DATA_HI = 7;
    localparam logic [1:0] ACC_READ = 2'h0;
    localparam logic [1:0] ACC_WRITE = 2'h1;

    // ----------------------------------------------------------------
    // register map and reset values
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_OPTION = 5'h08;
    localparam logic [4:0] ADDR_PIN_DRIVER = 5'h07;
    localparam logic [7:0] OPTION_RESET = 8'h00;
    localparam logic [7:0] PIN_DRIVER_RESET = 8'h00;
    localparam logic [7:0] READ_NONE = 8'h00;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic random_code_req;
        logic write_parity_enable;
        logic irq_pulse_select;
        logic irq_pulse_width;
        logic irq_half_period_flash;
        logic [2:0] debug_resistor_check;
    } ioopt_option_type;

    typedef struct packed {
        logic [5:0] other_pin_bits;
        logic io0_output_enable;
        logic cyclic_off_invert;
    } ioopt_pin_type;

    typedef struct packed {
        logic valid;
        logic supply_on;
        logic [2:0] code;
    } ioopt_lp_req_type;

    typedef enum logic [2:0] {
        IRQ_IDLE = 3'h1,
        IRQ_PULSE = 3'h2,
        IRQ_HOLD = 3'h4
    } ioopt_irq_state_type;

endpackage

// File: hw/ioopt_io0_drive.sv
// driver control of general pin 0, normal and cyclic-sense low-power operation
`timescale 1ns/1ps
module ioopt_io0_drive
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_output_enable,
    input wire logic i_cyclic_off_invert,
    input wire logic i_low_power_state,
    input wire logic i_cyclic_sense_sel,
    input wire logic i_active_window,
    input wire logic i_hs_req,
    input wire logic i_ls_req,
    output logic o_hs_on,
    output logic o_ls_on
);
    import ioopt_pkg::*;

    logic lp_q;
    logic saved_hs;
    logic saved_ls;
    logic next_saved_hs;
    logic next_saved_ls;
    logic next_hs;
    logic next_ls;

    always_comb
    begin
        next_saved_hs = saved_hs;
        next_saved_ls = saved_ls;
        // snapshot taken on the cycle low power begins
        if (i_low_power_state && !lp_q)
        begin
            next_saved_hs = o_hs_on;
            next_saved_ls = o_ls_on;
        end
        next_hs = 1'b0;
        next_ls = 1'b0;
        if (!i_output_enable)
        begin
            next_hs = 1'b0;
            next_ls = 1'b0;
        end
        else if (!i_low_power_state)
        begin
            // both requested would short the pin, so neither is driven
            next_hs = i_hs_req && !i_ls_req;
            next_ls = i_ls_req && !i_hs_req;
        end
        else if (!i_cyclic_sense_sel || i_active_window)
        begin
            next_hs = next_saved_hs;
            next_ls = next_saved_ls;
        end
        else if (!i_cyclic_off_invert)
        begin
            next_hs = 1'b0;
            next_ls = 1'b0;
        end
        else
        begin
            next_hs = next_saved_ls;
            next_ls = next_saved_hs;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            lp_q <= 1'b0;
            saved_hs <= 1'b0;
            saved_ls <= 1'b0;
            o_hs_on <= 1'b0;
            o_ls_on <= 1'b0;
        end
        else
        begin
            lp_q <= i_low_power_state;
            saved_hs <= next_saved_hs;
            saved_ls <= next_saved_ls;
            o_hs_on <= next_hs;
            o_ls_on <= next_ls;
        end
    end

endmodule

// File: hw/ioopt_regs.sv
// serial-written pin and option registers with low-power entry and interrupt shaping
//
// Functional notes
// - Cyclic active window restores pre-low-power driver state
// - Invert clear: both drivers off in off window
// - Invert set: opposite driver on in off window
// - Command byte: access, address 0_1000, parity
// - Option byte bit mapping seven down to zero
// - Bit seven gates random code in low-power entry
// - Random disabled: enter low power without code
// - Random enabled: entry needs matching code
// - Parity disabled: no parity check on writes
// - Pulse select: low pulse or permanent low
// - Width set: pulse about 25 microseconds
// - Flash bit: interrupt at half watchdog period, only in programming state
`timescale 1ns/1ps
module ioopt_regs
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_parity_error,
    input wire ioopt_pkg::ioopt_lp_req_type i_lp_req,
    input wire logic [2:0] i_lp_expected_code,
    output logic o_lp_enter_supply_off,
    output logic o_lp_enter_supply_on,
    output logic o_lp_code_reject,
    input wire logic i_low_power_state,
    input wire logic i_cyclic_sense_sel,
    input wire logic i_cyclic_active_window,
    input wire logic i_io0_hs_req,
    input wire logic i_io0_ls_req,
    output logic o_io0_hs_on,
    output logic o_io0_ls_on,
    input wire logic i_irq_event,
    input wire logic i_irq_release,
    input wire logic i_programming_state,
    input wire logic i_wd_half_elapsed,
    output logic o_irq_n,
    output ioopt_pkg::ioopt_option_type o_option
);
    import ioopt_pkg::*;

    // ----------------------------------------------------------------
    // serial slave
    // ----------------------------------------------------------------
    logic cs_n_q;
    logic sclk_q;
    logic [15:0] rx_shift;
    logic [15:0] tx_shift;
    logic [4:0] bit_cnt;
    logic [7:0] readback;
    logic [15:0] next_rx_shift;
    logic [15:0] next_tx_shift;
    logic [4:0] next_bit_cnt;
    logic [7:0] next_readback;
    logic next_miso;
    logic next_parity_error;
    logic write_option;
    logic write_pin;
    ioopt_pin_type pin_cfg;
    ioopt_pin_type next_pin_cfg;
    ioopt_option_type next_option;

    logic frame_start;
    logic frame_end;
    logic sclk_rise;
    logic sclk_fall;
    logic [1:0] acc;
    logic [4:0] addr;
    logic parity_ok;
    always_comb
    begin
        frame_start = cs_n_q && !i_spi_cs_n;
        frame_end = !cs_n_q && i_spi_cs_n;
        sclk_rise = !i_spi_cs_n && !sclk_q && i_spi_sclk;
        sclk_fall = !i_spi_cs_n && sclk_q && !i_spi_sclk;
        acc = rx_shift[CMD_ACC_HI:CMD_ACC_LO];
        addr = rx_shift[CMD_ADDR_HI:CMD_ADDR_LO];
        // parity not checked while disabled
        parity_ok = !o_option.write_parity_enable
            || (rx_shift[CMD_PARITY] == ^{rx_shift[15:9], rx_shift[DATA_HI:0]});

        next_rx_shift = rx_shift;
        next_tx_shift = tx_shift;
        next_bit_cnt = bit_cnt;
        next_readback = readback;
        next_miso = o_spi_miso;
        next_parity_error = 1'b0;
        write_option = 1'b0;
        write_pin = 1'b0;
        if (frame_start)
        begin
            next_bit_cnt = 5'h00;
            next_tx_shift = {readback, READ_NONE};
            next_miso = readback[DATA_HI];
        end
        else if (sclk_rise)
        begin
            next_rx_shift = {rx_shift[14:0], i_spi_mosi};
            if (bit_cnt != BIT_CNT_MAX)
                next_bit_cnt = bit_cnt + 5'h01;
        end
        else if (sclk_fall)
        begin
            next_tx_shift = {tx_shift[14:0], 1'b0};
            next_miso = tx_shift[14];
        end
        else if (frame_end)
        begin
            next_miso = 1'b0;
            // frames of the wrong length are dropped whole
            if (bit_cnt == FRAME_BITS)
            begin
                if (acc == ACC_WRITE)
                begin
                    next_parity_error = !parity_ok;
                    write_option = parity_ok && (addr == ADDR_OPTION);
                    write_pin = parity_ok && (addr == ADDR_PIN_DRIVER);
                end
                else if (acc == ACC_READ)
                begin
                    // unknown addresses read back as zero
                    next_readback = READ_NONE;
                    if (addr == ADDR_OPTION)
                        next_readback = o_option;
                    if (addr == ADDR_PIN_DRIVER)
                        next_readback = pin_cfg;
                end
            end
        end
        next_option = o_option;
        next_pin_cfg = pin_cfg;
        if (write_option)
            next_option = ioopt_option_type'(rx_shift[DATA_HI:0]);
        if (write_pin)
            next_pin_cfg = ioopt_pin_type'(rx_shift[DATA_HI:0]);
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            rx_shift <= 16'h0000;
            tx_shift <= 16'h0000;
            bit_cnt <= 5'h00;
            readback <= READ_NONE;
            o_spi_miso <= 1'b0;
            o_parity_error <= 1'b0;
            o_option <= ioopt_option_type'(OPTION_RESET);
            pin_cfg <= ioopt_pin_type'(PIN_DRIVER_RESET);
        end
        else
        begin
            cs_n_q <= i_spi_cs_n;
            sclk_q <= i_spi_sclk;
            rx_shift <= next_rx_shift;
            tx_shift <= next_tx_shift;
            bit_cnt <= next_bit_cnt;
            readback <= next_readback;
            o_spi_miso <= next_miso;
            o_parity_error <= next_parity_error;
            o_option <= next_option;
            pin_cfg <= next_pin_cfg;
        end
    end

    // ----------------------------------------------------------------
    // low-power entry
    // ----------------------------------------------------------------
    logic lp_allowed;
    logic next_enter_off;
    logic next_enter_on;
    logic next_reject;
    always_comb
    begin
        lp_allowed = !o_option.random_code_req
            || (i_lp_req.code == i_lp_expected_code);
        next_enter_off = i_lp_req.valid && lp_allowed && !i_lp_req.supply_on;
        next_enter_on = i_lp_req.valid && lp_allowed && i_lp_req.supply_on;
        next_reject = i_lp_req.valid && !lp_allowed;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_lp_enter_supply_off <= 1'b0;
            o_lp_enter_supply_on <= 1'b0;
            o_lp_code_reject <= 1'b0;
        end
        else
        begin
            o_lp_enter_supply_off <= next_enter_off;
            o_lp_enter_supply_on <= next_enter_on;
            o_lp_code_reject <= next_reject;
        end
    end

    // ----------------------------------------------------------------
    // interrupt output shaping
    // ----------------------------------------------------------------
    ioopt_irq_state_type irq_state;
    ioopt_irq_state_type next_irq_state;
    logic [11:0] irq_cnt;
    logic [11:0] next_irq_cnt;
    logic next_irq_n;
    logic irq_trigger;
    always_comb
    begin
        irq_trigger = i_irq_event
            || (o_option.irq_half_period_flash && i_programming_state
                && i_wd_half_elapsed);
        next_irq_state = irq_state;
        next_irq_cnt = irq_cnt;
        next_irq_n = o_irq_n;
        case (irq_state)
            IRQ_IDLE:
            begin
                if (irq_trigger)
                begin
                    next_irq_n = 1'b0;
                    next_irq_state = IRQ_PULSE;
                    next_irq_cnt = o_option.irq_pulse_width
                        ? IRQ_WIDE_CYC - 12'h001
                        : IRQ_NARROW_CYC - 12'h001;
                    if (o_option.irq_pulse_select)
                        next_irq_state = IRQ_HOLD;
                end
            end
            IRQ_PULSE:
            begin
                // triggers during a pulse merge into it
                if (irq_cnt == 12'h000)
                begin
                    next_irq_state = IRQ_IDLE;
                    next_irq_n = 1'b1;
                end
                else
                    next_irq_cnt = irq_cnt - 12'h001;
            end
            IRQ_HOLD:
            begin
                if (i_irq_release)
                begin
                    next_irq_state = IRQ_IDLE;
                    next_irq_n = 1'b1;
                end
            end
            default:
            begin
                next_irq_state = IRQ_IDLE;
                next_irq_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            irq_state <= IRQ_IDLE;
            irq_cnt <= 12'h000;
            o_irq_n <= 1'b1;
        end
        else
        begin
            irq_state <= next_irq_state;
            irq_cnt <= next_irq_cnt;
            o_irq_n <= next_irq_n;
        end
    end

    // ----------------------------------------------------------------
    // general pin 0 drivers
    // ----------------------------------------------------------------
    ioopt_io0_drive u_io0
    (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_output_enable(pin_cfg.io0_output_enable),
        .i_cyclic_off_invert(pin_cfg.cyclic_off_invert),
        .i_low_power_state(i_low_power_state),
        .i_cyclic_sense_sel(i_cyclic_sense_sel),
        .i_active_window(i_cyclic_active_window),
        .i_hs_req(i_io0_hs_req),
        .i_ls_req(i_io0_ls_req),
        .o_hs_on(o_io0_hs_on),
        .o_ls_on(o_io0_ls_on)
    );

endmodule

// File: verification/ioopt_regs_assertions.sv
// concurrent checks on the ports of the option register block
`timescale 1ns/1ps
module ioopt_regs_assertions
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire ioopt_pkg::ioopt_lp_req_type i_lp_req,
    input wire logic [2:0] i_lp_expected_code,
    input wire logic i_io0_hs_req,
    input wire logic i_io0_ls_req,
    input wire logic i_low_power_state,
    input wire logic i_irq_event,
    input wire logic i_irq_release,
    input wire logic i_programming_state,
    input wire logic i_wd_half_elapsed,
    input wire logic o_parity_error,
    input wire logic o_lp_enter_supply_off,
    input wire logic o_lp_enter_supply_on,
    input wire logic o_lp_code_reject,
    input wire logic o_io0_hs_on,
    input wire logic o_irq_n,
    input wire ioopt_pkg::ioopt_option_type o_option
);
    import ioopt_pkg::*;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic [11:0] low_cnt;
    logic [11:0] next_low_cnt;
    // ----------------------------------------------------------------
    // length of the current low interrupt level
    // ----------------------------------------------------------------
    always_comb
    begin
        next_low_cnt = o_irq_n ? 12'h000 : low_cnt + 12'h001;
    end
    always_ff @(posedge i_clk_sys)
    begin
        low_cnt <= i_rst ? 12'h000 : next_low_cnt;
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_reset_clear: assert property ($past(i_rst) |-> o_option == OPTION_RESET && o_irq_n)
        else $error("option or interrupt not cleared after reset");
    a_parity_keeps_opt: assert property (o_parity_error |-> $stable(o_option))
        else $error("option changed by a rejected write");
    a_lp_plain_off: assert property (i_lp_req.valid && !o_option.random_code_req
        && !i_lp_req.supply_on |=> o_lp_enter_supply_off)
        else $error("entry without code not granted");
    a_lp_code_reject: assert property (i_lp_req.valid && o_option.random_code_req
        && i_lp_req.code != i_lp_expected_code
        |=> o_lp_code_reject && !o_lp_enter_supply_on && !o_lp_enter_supply_off)
        else $error("wrong code not refused");
    a_lp_code_grant: assert property (i_lp_req.valid && o_option.random_code_req
        && i_lp_req.code == i_lp_expected_code && i_lp_req.supply_on
        |=> o_lp_enter_supply_on)
        else $error("matching code not granted");
    a_hs_needs_req: assert property (o_io0_hs_on && !$past(i_low_power_state)
        |-> $past(i_io0_hs_req) && !$past(i_io0_ls_req))
        else $error("high side on without request");
    a_irq_start: assert property (o_irq_n && i_irq_event |=> !o_irq_n)
        else $error("interrupt event not signalled");
    a_irq_flash: assert property (o_irq_n && o_option.irq_half_period_flash
        && i_programming_state && i_wd_half_elapsed |=> !o_irq_n)
        else $error("half period interrupt missing");
    a_irq_width: assert property ($rose(o_irq_n) && !o_option.irq_pulse_select
        |-> low_cnt == (o_option.irq_pulse_width ? IRQ_WIDE_CYC : IRQ_NARROW_CYC))
        else $error("interrupt pulse width wrong");
    a_irq_hold: assert property (o_option.irq_pulse_select && !o_irq_n
        && !i_irq_release |=> !o_irq_n)
        else $error("permanent interrupt level released early");
    c_parity_err: cover property (o_parity_error);
    c_lp_reject: cover property (o_lp_code_reject);
    c_irq_end: cover property ($rose(o_irq_n));
endmodule

// File: verification/ioopt_spi_master.sv
// serial master model standing in for the microcontroller
`timescale 1ns/1ps
module ioopt_spi_master
(
    input wire logic i_clk_sys,
    input wire logic i_miso,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_mosi
);
    logic [7:0] rd_byte = 8'h00;
    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
    end
    // parity stays 0 while the check is off
    function automatic logic [15:0] cmd(input logic [1:0] acc, input logic [4:0] addr,
        input logic [7:0] data, input logic par_on);
        logic [15:0] w;
        w = {acc, addr, 1'b0, data};
        w[8] = par_on & (^w);
        return w;
    endfunction
    // msb first; each sclk level held two system clocks
    task automatic frame(input logic [15:0] word);
        @(negedge i_clk_sys);
        o_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            o_mosi = word[i];
            repeat (2) @(negedge i_clk_sys);
            o_sclk = 1'b1;
            if (i > 7)
                rd_byte[i - 8] = i_miso;
            repeat (2) @(negedge i_clk_sys);
            o_sclk = 1'b0;
        end
        repeat (2) @(negedge i_clk_sys);
        o_cs_n = 1'b1;
        // released data line must not keep the last bit
        o_mosi = ~o_mosi;
        repeat (3) @(negedge i_clk_sys);
    endtask
endmodule

// File: verification/ioopt_regs_tb.sv
// self-checking bench for the io and low-power option registers
`timescale 1ns/1ps
module ioopt_regs_tb;
    import ioopt_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic cs_n, sclk, mosi, miso, perr, lp_off, lp_on, lp_rej, hs_on, ls_on, irq_n;
    logic lp_low = 1'b0, cyc_sel = 1'b1, act_win = 1'b1, hs_req = 1'b0, ls_req = 1'b0;
    logic irq_ev = 1'b0, irq_rel = 1'b0, prog = 1'b0, wd_half = 1'b0;
    logic par_on = 1'b0, perr_seen = 1'b0;
    logic [2:0] exp_code = 3'h2;
    ioopt_lp_req_type lp_req = '0;
    ioopt_option_type opt;
    int n_fail = 0, checks_done = 0, cycles = 0;

    ioopt_regs ioopt_regs_inst
    (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk),
        .i_spi_mosi(mosi), .o_spi_miso(miso), .o_parity_error(perr), .i_lp_req(lp_req),
        .i_lp_expected_code(exp_code), .o_lp_enter_supply_off(lp_off),
        .o_lp_enter_supply_on(lp_on), .o_lp_code_reject(lp_rej),
        .i_low_power_state(lp_low), .i_cyclic_sense_sel(cyc_sel),
        .i_cyclic_active_window(act_win), .i_io0_hs_req(hs_req), .i_io0_ls_req(ls_req),
        .o_io0_hs_on(hs_on), .o_io0_ls_on(ls_on), .i_irq_event(irq_ev),
        .i_irq_release(irq_rel), .i_programming_state(prog),
        .i_wd_half_elapsed(wd_half), .o_irq_n(irq_n), .o_option(opt)
    );
    ioopt_spi_master ioopt_spi_master_inst
    (
        .i_clk_sys(i_clk_sys), .i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi)
    );

    always #25 i_clk_sys = ~i_clk_sys;
    // ----------------------------------------------------------------
    // watchdog on the run and sticky parity flag
    // ----------------------------------------------------------------
    always @(posedge i_clk_sys)
    begin
        if (perr === 1'b1)
            perr_seen <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 12000)
        begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] addr, input logic [7:0] data, input logic bad);
        ioopt_spi_master_inst.frame(ioopt_spi_master_inst.cmd(ACC_WRITE, addr, data, par_on)
            ^ {7'h00, bad, 8'h00});
    endtask
    // second frame shifts out what the first one addressed
    task automatic rd(input logic [4:0] addr, input logic [7:0] exp);
        repeat (2) ioopt_spi_master_inst.frame(ioopt_spi_master_inst.cmd(ACC_READ, addr,
            8'h00, par_on));
        chk({4'h0, ioopt_spi_master_inst.rd_byte}, {4'h0, exp});
    endtask
    task automatic lp(input logic on, input logic [2:0] code, input logic [11:0] want);
        lp_req = '{valid: 1'b1, supply_on: on, code: code};
        @(negedge i_clk_sys);
        lp_req.valid = 1'b0;
        chk({9'h000, lp_rej, lp_on, lp_off}, want);
        @(negedge i_clk_sys);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic irq_len(input logic [11:0] want);
        logic [11:0] n;
        n = 12'h000;
        while (irq_n === 1'b0 && n < 12'hfff)
        begin
            n++;
            @(negedge i_clk_sys);
        end
        chk(n, want);
    endtask

    initial
    begin
        wait_cyc(4);
        i_rst = 1'b0;
        wait_cyc(1);
        chk({3'h0, irq_n, opt}, {3'h0, 1'b1, OPTION_RESET});
        rd(ADDR_OPTION, OPTION_RESET);
        rd(ADDR_PIN_DRIVER, PIN_DRIVER_RESET);
        lp(1'b0, 3'h5, 12'h001);
        wr(ADDR_OPTION, 8'h80, 1'b0);
        chk(12'(opt), 12'h080);
        lp(1'b1, 3'h3, 12'h004);
        lp(1'b1, 3'h2, 12'h002);
        lp(1'b0, 3'h2, 12'h001);
        hs_req = 1'b1;
        wr(ADDR_PIN_DRIVER, 8'h00, 1'b0);
        chk({10'h000, hs_on, ls_on}, 12'h000);
        wr(ADDR_PIN_DRIVER, 8'h02, 1'b0);
        chk({10'h000, hs_on, ls_on}, 12'h002);
        lp_low = 1'b1;
        wait_cyc(2);
        hs_req = 1'b0;
        wait_cyc(2);
        chk({10'h000, hs_on, ls_on}, 12'h002);
        act_win = 1'b0;
        wait_cyc(2);
        chk({10'h000, hs_on, ls_on}, 12'h000);
        lp_low = 1'b0;
        act_win = 1'b1;
        hs_req = 1'b1;
        wr(ADDR_PIN_DRIVER, 8'h03, 1'b0);
        lp_low = 1'b1;
        wait_cyc(2);
        hs_req = 1'b0;
        act_win = 1'b0;
        wait_cyc(2);
        chk({10'h000, hs_on, ls_on}, 12'h001);
        act_win = 1'b1;
        wait_cyc(2);
        chk({10'h000, hs_on, ls_on}, 12'h002);
        lp_low = 1'b0;
        rd(ADDR_PIN_DRIVER, 8'h03);
        wr(5'h1f, 8'hff, 1'b0);
        chk(12'(opt), 12'h080);
        rd(5'h1f, READ_NONE);
        wr(ADDR_OPTION, 8'h40, 1'b0);
        chk(12'(opt), 12'h040);
        par_on = 1'b1;
        wr(ADDR_OPTION, 8'h47, 1'b1);
        chk({3'h0, perr_seen, opt}, 12'h140);
        wr(ADDR_OPTION, 8'h57, 1'b0);
        rd(ADDR_OPTION, 8'h57);
        irq_ev = 1'b1;
        wait_cyc(1);
        irq_ev = 1'b0;
        irq_len(IRQ_WIDE_CYC);
        wr(ADDR_OPTION, 8'h60, 1'b0);
        irq_ev = 1'b1;
        wait_cyc(1);
        irq_ev = 1'b0;
        wait_cyc(600);
        chk({11'h000, irq_n}, 12'h000);
        irq_rel = 1'b1;
        wait_cyc(1);
        irq_rel = 1'b0;
        chk({11'h000, irq_n}, 12'h001);
        wr(ADDR_OPTION, 8'h48, 1'b0);
        prog = 1'b1;
        wd_half = 1'b1;
        wait_cyc(1);
        wd_half = 1'b0;
        irq_len(IRQ_NARROW_CYC);
        i_rst = 1'b1;
        wait_cyc(2);
        i_rst = 1'b0;
        wait_cyc(1);
        chk({3'h0, irq_n, opt}, {3'h0, 1'b1, OPTION_RESET});
        rd(ADDR_PIN_DRIVER, PIN_DRIVER_RESET);
        wrap_up();
    end
endmodule

bind ioopt_regs ioopt_regs_assertions ioopt_regs_assertions_inst
(
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_lp_req(i_lp_req),
    .i_lp_expected_code(i_lp_expected_code), .i_io0_hs_req(i_io0_hs_req),
    .i_io0_ls_req(i_io0_ls_req), .i_low_power_state(i_low_power_state),
    .i_irq_event(i_irq_event), .i_irq_release(i_irq_release),
    .i_programming_state(i_programming_state), .i_wd_half_elapsed(i_wd_half_elapsed),
    .o_parity_error(o_parity_error), .o_lp_enter_supply_off(o_lp_enter_supply_off),
    .o_lp_enter_supply_on(o_lp_enter_supply_on), .o_lp_code_reject(o_lp_code_reject),
    .o_io0_hs_on(o_io0_hs_on), .o_irq_n(o_irq_n), .o_option(o_option)
);
